// ===== core/smi_inputs.sv
// Input selection, counter and capture latches of the measurement timer
`timescale 1ns/1ps
`default_nettype none
`include "smi_regs.svh"
module smi_inputs
  import smi_pkg::*;
#(
  parameter int INSTANCE = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic [31:0] windowSources,
  input wire logic [31:0] signalSources,
  input wire logic countEnable,
  input wire smi_load_s loadReq,
  output logic windowSelected,
  output logic signalSelected,
  output smi_word_t measureCounter,
  output logic periodMatch
);
  // ****************************************************************************
  // Registers
  // ****************************************************************************
  localparam logic [4:0] OWN_CODE = (INSTANCE == 2) ? `SMI_CODE_MATCH2 : `SMI_CODE_MATCH1;
  logic [4:0] winCode_q, winCode_d, sigCode_q, sigCode_d;
  smi_ctrl_s ctrl_q, ctrl_d;
  smi_word_t cnt_q, cnt_d, period_q, period_d;
  smi_word_t cpr_q, cpr_d, cpw_q, cpw_d;
  logic [7:0] rd_q, rd_d;
  logic match_q, match_d;
  logic hit;

  // Next state of all software and hardware held state
  always_comb begin
    winCode_d = winCode_q;
    sigCode_d = sigCode_q;
    ctrl_d = ctrl_q;
    period_d = period_q;
    cnt_d = cnt_q;
    cpr_d = cpr_q;
    cpw_d = cpw_q;
    hit = (cnt_q == period_q);
    match_d = countEnable && hit;
    if (countEnable) begin
      if (hit) begin
        cnt_d = ctrl_q.halt ? period_q : `SMI_CNT_RESET;
      end else begin
        cnt_d = cnt_q + 24'h000001;
      end
    end
    // Latches move only on hardware strobes; their addresses ignore writes
    if (loadReq.loadPeriod) begin
      cpr_d = loadReq.periodVal;
    end
    if (loadReq.loadWidth) begin
      cpw_d = loadReq.widthVal;
    end
    // A software write wins over counting in the same cycle
    if (wrStrobe) begin
      case (addr)
        `SMI_OFF_WIN: winCode_d = wrData[4:0];
        `SMI_OFF_SIG: sigCode_d = wrData[4:0];
        `SMI_OFF_TMRL: cnt_d[7:0] = wrData;
        `SMI_OFF_TMRH: cnt_d[15:8] = wrData;
        `SMI_OFF_TMRU: cnt_d[23:16] = wrData;
        `SMI_OFF_CTRL: ctrl_d = wrData[2:0];
        `SMI_OFF_PRL: period_d[7:0] = wrData;
        `SMI_OFF_PRH: period_d[15:8] = wrData;
        `SMI_OFF_PRU: period_d[23:16] = wrData;
        default: ;
      endcase
    end
    // Read data, upper selector bits forced to zero
    rd_d = 8'h00;
    if (rdStrobe) begin
      case (addr)
        `SMI_OFF_WIN: rd_d = {3'h0, winCode_q};
        `SMI_OFF_SIG: rd_d = {3'h0, sigCode_q};
        `SMI_OFF_TMRL: rd_d = cnt_q[7:0];
        `SMI_OFF_TMRH: rd_d = cnt_q[15:8];
        `SMI_OFF_TMRU: rd_d = cnt_q[23:16];
        `SMI_OFF_CPRL: rd_d = cpr_q[7:0];
        `SMI_OFF_CPRH: rd_d = cpr_q[15:8];
        `SMI_OFF_CPRU: rd_d = cpr_q[23:16];
        `SMI_OFF_CPWL: rd_d = cpw_q[7:0];
        `SMI_OFF_CPWH: rd_d = cpw_q[15:8];
        `SMI_OFF_CTRL: rd_d = {5'h00, ctrl_q};
        `SMI_OFF_PRL: rd_d = period_q[7:0];
        `SMI_OFF_PRH: rd_d = period_q[15:8];
        `SMI_OFF_PRU: rd_d = period_q[23:16];
        default: rd_d = 8'h00;
      endcase
    end
  end

  // Latches carry no reset so they stay undefined until first loaded
  always_ff @(posedge clk) begin
    cpr_q <= cpr_d;
    cpw_q <= cpw_d;
  end

  // Reset clears selectors and counter on every reset
  always_ff @(posedge clk) begin
    if (reset) begin
      winCode_q <= `SMI_SEL_RESET;
      sigCode_q <= `SMI_SEL_RESET;
      ctrl_q <= '0;
      cnt_q <= `SMI_CNT_RESET;
      period_q <= `SMI_PR_RESET;
      rd_q <= 8'h00;
      match_q <= 1'b0;
    end else begin
      winCode_q <= winCode_d;
      sigCode_q <= sigCode_d;
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      period_q <= period_d;
      rd_q <= rd_d;
      match_q <= match_d;
    end
  end

  // ****************************************************************************
  // Source selection
  // ****************************************************************************
  smi_source_mux #(.LAST_CODE(`SMI_WIN_LAST), .OWN_CODE(OWN_CODE)) winMux (
    .sources(windowSources),
    .code(winCode_q),
    .invert(ctrl_q.winPol),
    .selected(windowSelected)
  );
  smi_source_mux #(.LAST_CODE(`SMI_SIG_LAST), .OWN_CODE(OWN_CODE)) sigMux (
    .sources(signalSources),
    .code(sigCode_q),
    .invert(ctrl_q.sigPol),
    .selected(signalSelected)
  );

  assign rdData = rd_q;
  assign measureCounter = cnt_q;
  assign periodMatch = match_q;
endmodule : smi_inputs
`default_nettype wire

// ===== core/smi_pkg.sv
// Types shared by the measurement timer input block
package smi_pkg;
  typedef logic [23:0] smi_word_t;
  typedef struct packed {
    logic halt;
    logic winPol;
    logic sigPol;
  } smi_ctrl_s;
  typedef struct packed {
    logic loadPeriod;
    logic loadWidth;
    smi_word_t periodVal;
    smi_word_t widthVal;
  } smi_load_s;
endpackage : smi_pkg

// ===== core/smi_regs.svh
// Register offsets, field layout, reset values and selector codes of the measurement timer inputs
// ****************************************************************************
// What this block does
// - The window selector is five bits at 4..0 and bits 7..5 always read zero.
// - Window codes 00000..10111 route the pin, oscillators and peripheral outputs; 11000 and up are reserved.
// - The signal selector is five bits at 4..0, bits 7..5 read zero, codes 00000..11000 route sources.
// - Codes 01000 and 01001 pick the match output of timer 1 or 2, and an instance's own code is reserved.
// - The 24-bit counter is three read-write bytes that clear to zero on every reset.
// - The 24-bit captured-period latch is three read-only bytes, undefined until first loaded.
// - The captured-width latch has read-only low and high bytes, undefined until first loaded.
// - Window polarity set inverts the selected window input.
// - Signal polarity set inverts the selected measured signal.
// - At counter equal to period the counter wraps to zero and a match pulse fires; with halt set it holds and the match stays high while counting.
// ****************************************************************************
`ifndef SMI_REGS_SVH
`define SMI_REGS_SVH
`define SMI_ADDR_W 4
`define SMI_OFF_WIN 4'h0
`define SMI_OFF_SIG 4'h1
`define SMI_OFF_TMRL 4'h2
`define SMI_OFF_TMRH 4'h3
`define SMI_OFF_TMRU 4'h4
`define SMI_OFF_CPRL 4'h5
`define SMI_OFF_CPRH 4'h6
`define SMI_OFF_CPRU 4'h7
`define SMI_OFF_CPWL 4'h8
`define SMI_OFF_CPWH 4'h9
`define SMI_OFF_CTRL 4'ha
`define SMI_OFF_PRL 4'hb
`define SMI_OFF_PRH 4'hc
`define SMI_OFF_PRU 4'hd
`define SMI_SEL_W 5
`define SMI_CTRL_HALT 2
`define SMI_CTRL_WINDOW_POLARITY 1
`define SMI_CTRL_SIGNAL_POLARITY 0
`define SMI_CTRL_MASK 8'h07
`define SMI_WIN_LAST 5'h17
`define SMI_SIG_LAST 5'h18
`define SMI_CODE_MATCH1 5'h08
`define SMI_CODE_MATCH2 5'h09
`define SMI_SEL_RESET 5'h00
`define SMI_CNT_RESET 24'h000000
`define SMI_PR_RESET 24'hffffff
`endif

// ===== core/smi_source_mux.sv
// Five-bit source selector with reserved codes and polarity inversion
`timescale 1ns/1ps
`default_nettype none
`include "smi_regs.svh"
module smi_source_mux #(
  parameter logic [4:0] LAST_CODE = 5'h17,
  parameter logic [4:0] OWN_CODE = 5'h08
) (
  input wire logic [31:0] sources,
  input wire logic [4:0] code,
  input wire logic invert,
  output logic selected
);
  logic raw;
  // Reserved and own-match codes give a quiet low before polarity
  always_comb begin
    if (code > LAST_CODE || code == OWN_CODE) begin
      raw = 1'b0;
    end else begin
      raw = sources[code];
    end
    selected = raw ^ invert;
  end
endmodule : smi_source_mux
`default_nettype wire

// ===== test/smi_properties.sv
// Concurrent checks on the measurement timer input ports
`timescale 1ns/1ps
`default_nettype none
`include "smi_regs.svh"
module smi_properties
  import smi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic countEnable,
  input wire smi_word_t measureCounter,
  input wire logic periodMatch
);
  // One domain, so clock and reset are given once for every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_sel_upper_zero: assert property (
    rdStrobe && addr <= `SMI_OFF_SIG |=> rdData[7:5] == 3'h0) else $error("top bits set");
  a_cnt_clear: assert property (
    $fell(reset) |-> measureCounter == `SMI_CNT_RESET) else $error("counter not cleared");
  a_cnt_read: assert property (
    rdStrobe && addr == `SMI_OFF_TMRL |=> rdData == $past(measureCounter[7:0]))
    else $error("counter byte misread");
  a_cnt_step: assert property (
    countEnable && !wrStrobe |=> measureCounter == $past(measureCounter) + 24'h1 || periodMatch)
    else $error("counter skipped");
  a_match_wrap: assert property (
    periodMatch && !$past(wrStrobe) |-> measureCounter == 24'h0 || $stable(measureCounter))
    else $error("no wrap or hold");
  a_match_cause: assert property (
    periodMatch |-> $past(countEnable)) else $error("match while idle");
  // Read data must not linger, or software sees stale bytes
  a_rd_idle: assert property (
    !rdStrobe |=> rdData == 8'h00) else $error("read data lingers");
  a_idle_hold: assert property (
    !countEnable && !wrStrobe |=> $stable(measureCounter)) else $error("counter drifts");
endmodule : smi_properties
bind smi_inputs smi_properties u_smi_properties (.clk, .reset, .addr, .wrStrobe, .rdStrobe,
  .rdData, .countEnable, .measureCounter, .periodMatch);
`default_nettype wire

// ===== test/smi_source_model.sv
// Far-side peripheral outputs feeding both source selectors
`timescale 1ns/1ps
`default_nettype none
module smi_source_model (
  input wire logic clk,
  input wire logic [31:0] pattern,
  output logic [31:0] windowSources,
  output logic [31:0] signalSources
);
  // Outputs move only at edges, as synchronised peripheral lines would
  always_ff @(posedge clk) begin
    windowSources <= pattern;
    signalSources <= pattern;
  end
endmodule : smi_source_model
`default_nettype wire

// ===== test/tb_smi_inputs.sv
// Register-level bench for the measurement timer inputs
`timescale 1ns/1ps
`default_nettype none
`include "smi_regs.svh"
module tb_smi_inputs import smi_pkg::*; ;
  logic clk = 0, reset = 1, wrStrobe = 0, rdStrobe = 0, countEnable = 0, own;
  logic [3:0] addr = 0;
  logic [7:0] wrData = 0, rdData;
  logic [31:0] pattern = 0, windowSources, signalSources;
  logic windowSelected, signalSelected, periodMatch;
  smi_word_t measureCounter;
  smi_load_s loadReq = '0;
  int fail_count = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  smi_source_model u_smi_source_model (.clk, .pattern, .windowSources, .signalSources);
  smi_inputs u_smi_inputs (.clk, .reset, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
    .windowSources, .signalSources, .countEnable, .loadReq, .windowSelected,
    .signalSelected, .measureCounter, .periodMatch);
  // Mismatches are counted, not fatal, so one run shows every fault
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Strobes rise after one edge and drop after the edge that takes them
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {wrStrobe, addr, wrData} <= {1'b1, a, d};
    @(posedge clk) wrStrobe <= 0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) {rdStrobe, addr} <= {1'b1, a};
    @(posedge clk) rdStrobe <= 0;
    #1 check(rdData, e);
  endtask : rd
  // Bounded wait; running out ends the run as a failure
  task automatic wait_match();
    int k;
    for (k = 0; k < 64 && periodMatch !== 1'b1; k++) @(posedge clk) #1;
    if (k == 64) begin
      fail_count++;
      print_verdict();
    end
  endtask : wait_match
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    rd(`SMI_OFF_TMRU, 8'h00);
    wr(`SMI_OFF_WIN, 8'hff);
    wr(`SMI_OFF_SIG, 8'hff);
    rd(`SMI_OFF_WIN, 8'h1f);
    rd(`SMI_OFF_SIG, 8'h1f);
    // One-hot sources: each code must pick only its own line, in both polarities
    for (int p = 0; p < 2; p++) begin
      wr(`SMI_OFF_CTRL, 8'(p * 3));
      for (int c = 0; c < 32; c++) begin
        pattern <= 32'h1 << c;
        wr(`SMI_OFF_WIN, 8'(c));
        wr(`SMI_OFF_SIG, 8'(c));
        #1 own = c != `SMI_CODE_MATCH1;
        check(windowSelected, p ^ (own && c <= `SMI_WIN_LAST));
        check(signalSelected, p ^ (own && c <= `SMI_SIG_LAST));
      end
    end
    // Period stays at its reset value, so start just below it
    wr(`SMI_OFF_TMRL, 8'hfa);
    wr(`SMI_OFF_TMRH, 8'hff);
    wr(`SMI_OFF_TMRU, 8'hff);
    rd(`SMI_OFF_TMRL, 8'hfa);
    check(measureCounter, 24'hfffffa);
    @(posedge clk) countEnable <= 1;
    wait_match();
    check(measureCounter, 24'h0);
    wr(`SMI_OFF_CTRL, 8'h04);
    wr(`SMI_OFF_TMRU, 8'hff);
    wr(`SMI_OFF_TMRH, 8'hff);
    wr(`SMI_OFF_TMRL, 8'hf0);
    wait_match();
    check(measureCounter, `SMI_PR_RESET);
    @(posedge clk) countEnable <= 0;
    loadReq <= '{1'b1, 1'b1, 24'habcdef, 24'h001234};
    @(posedge clk) loadReq <= '0;
    wr(`SMI_OFF_CPRL, 8'h00);
    wr(`SMI_OFF_CPWH, 8'hff);
    rd(`SMI_OFF_CPRL, 8'hef);
    rd(`SMI_OFF_CPRH, 8'hcd);
    rd(`SMI_OFF_CPRU, 8'hab);
    rd(`SMI_OFF_CPWL, 8'h34);
    rd(`SMI_OFF_CPWH, 8'h12);
    rd(`SMI_OFF_CTRL, 8'h04);
    // Reset in mid-run must clear the counter and window selector again
    @(posedge clk) reset <= 1;
    @(posedge clk) reset <= 0;
    rd(`SMI_OFF_TMRU, 8'h00);
    rd(`SMI_OFF_TMRL, 8'h00);
    rd(`SMI_OFF_WIN, 8'h00);
    rd(4'he, 8'h00);
    print_verdict();
  end
endmodule : tb_smi_inputs
`default_nettype wire
